// *** verilog/trs_pkg.sv ***
// constants, types and bit layouts shared by the timer request/event/sync block
package trs_pkg;
  localparam int CH_NUM = 4;
  localparam int SYNC_W = 24;
  localparam int IRQ_W = 20;
  localparam int EVI_W = 6;
  localparam int SYNC_TICKS_DEF = 2;
  localparam int SYNC_CNT_W = 4;

  // crossing-pending bit positions, one per write-synchronised register
  localparam int SB_SOFT_RESET = 0;
  localparam int SB_ENABLE = 1;
  localparam int SB_CTRLB = 2;
  localparam int SB_STATUS = 3;
  localparam int SB_COUNT = 4;
  localparam int SB_OVERRIDE = 5;
  localparam int SB_WAVE = 6;
  localparam int SB_LENGTH = 7;
  localparam int SB_COMPARE0 = 8;
  localparam int SB_OVERRIDE_BUF = 16;
  localparam int SB_SHAPE_BUF = 17;
  localparam int SB_LENGTH_BUF = 18;
  localparam int SB_COMPARE_BUF0 = 19;
  // writes that drop the update request: cycle length, compare, override, shape
  localparam logic [SYNC_W-1:0] UPD_CLR_MASK = 24'h7f0fe0;
  localparam logic [SYNC_W-1:0] SYNC_RST = 24'h000000;

  // interrupt flag positions
  localparam int IF_WRAP = 0;
  localparam int IF_RETRIG = 1;
  localparam int IF_COUNT = 2;
  localparam int IF_CAPT_ERR = 3;
  localparam int IF_SYNC_RDY = 4;
  localparam int IF_DEBUG = 11;
  localparam int IF_REC0 = 12;
  localparam int IF_UNREC0 = 14;
  localparam int IF_MATCH0 = 16;
  localparam logic [IRQ_W-1:0] IRQ_RST = 20'h00000;

  // event input sync vector layout
  localparam int EVI_ZERO = 0;
  localparam int EVI_ONE = 1;
  localparam int EVI_CH0 = 2;

  typedef enum logic [2:0] {
    A0_OFF = 3'h0, A0_RETRIG = 3'h1, A0_COUNT = 3'h2, A0_START = 3'h3,
    A0_INC = 3'h4, A0_ACTIVE = 3'h5, A0_FAULT = 3'h7
  } trs_ev0_act_t;

  typedef enum logic [2:0] {
    A1_OFF = 3'h0, A1_RETRIG = 3'h1, A1_DIR = 3'h2, A1_STOP = 3'h3,
    A1_DEC = 3'h4, A1_PPW = 3'h5, A1_PWP = 3'h6, A1_FAULT = 3'h7
  } trs_ev1_act_t;

  typedef struct packed {
    logic wrap;
    logic retrig;
    logic count;
    logic [CH_NUM-1:0] match;
  } trs_event_out_t;

  typedef struct packed {
    logic retrigger;
    logic count_step;
    logic start;
    logic increment;
    logic decrement;
    logic count_down;
    logic stop;
    logic period_capture;
    logic width_capture;
    logic fault_zero;
    logic fault_one;
  } trs_counter_cmd_t;
endpackage

// *** verilog/trs_write_sync.sv ***
// per-register write crossing tracker, paced by the counting clock enable
`timescale 1ns/100ps
module trs_write_sync #(
  parameter int W = 24,
  parameter int unsigned SYNC_TICKS = 2
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] write_i,
  input wire logic slow_tick_i,
  output logic [W-1:0] busy_o,
  output logic [W-1:0] done_o
);
  import trs_pkg::*;

  if (SYNC_TICKS < 1 || SYNC_TICKS > 15) begin : g_bad
    $error("trs_write_sync: SYNC_TICKS must be 1..15");
  end

  // one tracker per bit; a write while busy is ignored here, the top flags it
  for (genvar i = 0; i < W; i++) begin : g_bit
    logic [SYNC_CNT_W-1:0] cnt;
    logic [SYNC_CNT_W-1:0] next_cnt;
    logic next_busy;
    logic next_done;

    always_comb begin
      next_cnt = cnt;
      next_busy = busy_o[i];
      next_done = 1'b0;
      if (busy_o[i]) begin
        if (slow_tick_i) begin
          if (cnt == SYNC_CNT_W'(SYNC_TICKS - 1)) begin
            next_busy = 1'b0;
            next_done = 1'b1;
          end else begin
            next_cnt = cnt + 4'h1;
          end
        end
      end else if (write_i[i]) begin
        next_busy = 1'b1;
        next_cnt = '0;
      end
    end

    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        cnt <= '0;
        busy_o[i] <= 1'b0;
        done_o[i] <= 1'b0;
      end else begin
        cnt <= next_cnt;
        busy_o[i] <= next_busy;
        done_o[i] <= next_done;
      end
    end
  end
endmodule

// *** verilog/trs_request_event.sv ***
// request, interrupt, event and write-crossing logic of the control timer
`timescale 1ns/100ps
module trs_request_event #(
  parameter int unsigned SYNC_TICKS = trs_pkg::SYNC_TICKS_DEF
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wrap_i,
  input wire logic retrig_i,
  input wire logic count_i,
  input wire logic [trs_pkg::CH_NUM-1:0] match_i,
  input wire logic [trs_pkg::CH_NUM-1:0] capture_i,
  input wire logic [trs_pkg::CH_NUM-1:0] cc_read_i,
  input wire logic [trs_pkg::CH_NUM-1:0] capture_mode_i,
  input wire logic debug_fault_i,
  input wire logic [1:0] rec_fault_i,
  input wire logic [trs_pkg::IRQ_W-1:0] irq_flags_clear_i,
  input wire logic [trs_pkg::IRQ_W-1:0] irq_mask_set_i,
  input wire logic [trs_pkg::IRQ_W-1:0] irq_mask_clear_i,
  input wire trs_pkg::trs_event_out_t event_out_enable_i,
  input wire logic [trs_pkg::CH_NUM-1:0] channel_event_in_enable_i,
  input wire logic [trs_pkg::CH_NUM-1:0] channel_fault_select_i,
  input wire logic [1:0] counter_event_in_enable_i,
  input wire trs_pkg::trs_ev0_act_t event_zero_action_select_i,
  input wire trs_pkg::trs_ev1_act_t event_one_action_select_i,
  input wire logic counter_event_zero_i,
  input wire logic counter_event_one_i,
  input wire logic [trs_pkg::CH_NUM-1:0] channel_event_i,
  input wire logic prescale_tick_i,
  input wire logic counting_tick_i,
  input wire logic counter_running_i,
  input wire logic keep_running_in_sleep_i,
  input wire logic standby_i,
  input wire logic [trs_pkg::SYNC_W-1:0] reg_write_i,
  output logic dma_update_o,
  output logic [trs_pkg::CH_NUM-1:0] dma_channel_o,
  output logic irq_o,
  output logic [trs_pkg::IRQ_W-1:0] irq_flags_o,
  output trs_pkg::trs_event_out_t event_out_o,
  output trs_pkg::trs_counter_cmd_t counter_cmd_o,
  output logic [trs_pkg::CH_NUM-1:0] channel_capture_o,
  output logic [trs_pkg::CH_NUM-1:0] channel_fault_o,
  output logic clock_request_o,
  output logic wake_o,
  output logic [trs_pkg::SYNC_W-1:0] crossing_pending_flags_o,
  output logic [trs_pkg::SYNC_W-1:0] write_applied_o,
  output logic sync_violation_o
);
  import trs_pkg::*;

  logic [EVI_W-1:0] ev_meta;
  logic [EVI_W-1:0] ev_sync;
  logic [EVI_W-1:0] ev_prev;
  logic [EVI_W-1:0] ev_rise;
  logic [EVI_W-1:0] ev_fall;
  logic [IRQ_W-1:0] irq_mask;
  logic [IRQ_W-1:0] next_flags;
  logic [IRQ_W-1:0] next_mask;
  logic [IRQ_W-1:0] flag_set;
  logic next_irq;
  logic next_dma_update;
  logic [CH_NUM-1:0] next_dma_channel;
  logic [CH_NUM-1:0] chan_set;
  logic [CH_NUM-1:0] chan_clr;
  logic [CH_NUM-1:0] capt_err;
  logic [CH_NUM-1:0] chan_rise;
  logic [CH_NUM-1:0] next_chan_capture;
  logic [CH_NUM-1:0] next_chan_fault;
  trs_event_out_t next_event_out;
  trs_counter_cmd_t next_cmd;
  logic next_violation;
  logic next_clock_request;

  // event inputs come from the routing fabric, so two stages before use
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ev_meta <= '0;
      ev_sync <= '0;
      ev_prev <= '0;
    end else begin
      ev_meta <= {channel_event_i, counter_event_one_i, counter_event_zero_i};
      ev_sync <= ev_meta;
      ev_prev <= ev_sync;
    end
  end

  assign ev_rise = ev_sync & ~ev_prev;
  assign ev_fall = ~ev_sync & ev_prev;
  assign chan_rise = ev_rise[EVI_CH0 +: CH_NUM];

  // write crossing tracker, paced by the counting clock enable
  trs_write_sync #(
    .W(SYNC_W),
    .SYNC_TICKS(SYNC_TICKS)
  ) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .write_i(reg_write_i),
    .slow_tick_i(counting_tick_i),
    .busy_o(crossing_pending_flags_o),
    .done_o(write_applied_o)
  );

  // counter event actions; a retrigger on both inputs is merged into one pulse
  always_comb begin
    next_cmd = '0;
    next_cmd.count_down = counter_cmd_o.count_down; // direction level holds
    if (counter_event_in_enable_i[0]) begin
      case (event_zero_action_select_i)
        A0_RETRIG: next_cmd.retrigger = ev_rise[EVI_ZERO];
        A0_COUNT: next_cmd.count_step = ev_rise[EVI_ZERO];
        A0_START: next_cmd.start = ev_rise[EVI_ZERO] & ~counter_running_i;
        A0_INC: next_cmd.increment = ev_rise[EVI_ZERO];
        A0_ACTIVE: next_cmd.count_step = ev_sync[EVI_ZERO] & prescale_tick_i;
        A0_FAULT: next_cmd.fault_zero = ev_rise[EVI_ZERO];
        default: ;
      endcase
    end
    if (counter_event_in_enable_i[1]) begin
      case (event_one_action_select_i)
        A1_RETRIG: next_cmd.retrigger = next_cmd.retrigger | ev_rise[EVI_ONE];
        A1_DIR: next_cmd.count_down = ev_sync[EVI_ONE];
        A1_STOP: next_cmd.stop = ev_rise[EVI_ONE];
        A1_DEC: next_cmd.decrement = ev_rise[EVI_ONE];
        A1_PPW: begin
          next_cmd.period_capture = ev_rise[EVI_ONE];
          next_cmd.width_capture = ev_fall[EVI_ONE];
        end
        A1_PWP: begin
          next_cmd.period_capture = ev_fall[EVI_ONE];
          next_cmd.width_capture = ev_rise[EVI_ONE];
        end
        A1_FAULT: next_cmd.fault_one = ev_rise[EVI_ONE];
        default: ;
      endcase
    end
    // channel events: capture or recoverable fault, per channel choice
    next_chan_capture = chan_rise & channel_event_in_enable_i & ~channel_fault_select_i;
    next_chan_fault = chan_rise & channel_event_in_enable_i & channel_fault_select_i;
    // output events, gated by their enables
    next_event_out.wrap = event_out_enable_i.wrap & wrap_i;
    next_event_out.retrig = event_out_enable_i.retrig & retrig_i;
    next_event_out.count = event_out_enable_i.count & count_i;
    next_event_out.match = event_out_enable_i.match & (match_i | capture_i);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      counter_cmd_o <= '0;
      channel_capture_o <= '0;
      channel_fault_o <= '0;
      event_out_o <= '0;
    end else begin
      counter_cmd_o <= next_cmd;
      channel_capture_o <= next_chan_capture;
      channel_fault_o <= next_chan_fault;
      event_out_o <= next_event_out;
    end
  end

  // dma requests; a set in the same cycle as a clear wins
  always_comb begin
    chan_set = (match_i & ~capture_mode_i) | (capture_i & capture_mode_i);
    chan_clr = (reg_write_i[SB_COMPARE_BUF0 +: CH_NUM] & ~capture_mode_i)
      | (cc_read_i & capture_mode_i);
    next_dma_channel = (dma_channel_o & ~chan_clr) | chan_set;
    next_dma_update = dma_update_o;
    if (|(reg_write_i & UPD_CLR_MASK)) begin
      next_dma_update = 1'b0;
    end
    if (wrap_i | retrig_i) begin
      next_dma_update = 1'b1;
    end
    // a read in the same cycle takes the old value, so no overrun then
    capt_err = capture_i & capture_mode_i & dma_channel_o & ~cc_read_i;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dma_update_o <= 1'b0;
      dma_channel_o <= '0;
    end else begin
      dma_update_o <= next_dma_update;
      dma_channel_o <= next_dma_channel;
    end
  end

  // interrupt flags, mask and the single shared line
  always_comb begin
    flag_set = '0;
    flag_set[IF_WRAP] = wrap_i;
    flag_set[IF_RETRIG] = retrig_i;
    flag_set[IF_COUNT] = count_i;
    flag_set[IF_CAPT_ERR] = |capt_err;
    flag_set[IF_SYNC_RDY] = |write_applied_o;
    flag_set[IF_DEBUG] = debug_fault_i;
    flag_set[IF_REC0 +: 2] = rec_fault_i;
    flag_set[IF_UNREC0] = next_cmd.fault_zero;
    flag_set[IF_UNREC0 + 1] = next_cmd.fault_one;
    flag_set[IF_MATCH0 +: CH_NUM] = match_i | capture_i;
    // set beats clear so an event in the clearing cycle survives
    next_flags = (irq_flags_o & ~irq_flags_clear_i) | flag_set;
    next_mask = (irq_mask | irq_mask_set_i) & ~irq_mask_clear_i;
    next_irq = |(next_flags & next_mask);
    // a busy register touched again: the write is dropped and reported
    next_violation = |(reg_write_i & crossing_pending_flags_o);
    next_clock_request = ~standby_i | keep_running_in_sleep_i;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_flags_o <= IRQ_RST;
      irq_mask <= IRQ_RST;
      irq_o <= 1'b0;
      wake_o <= 1'b0;
      sync_violation_o <= 1'b0;
      clock_request_o <= 1'b1;
    end else begin
      irq_flags_o <= next_flags;
      irq_mask <= next_mask;
      irq_o <= next_irq;
      wake_o <= next_irq;
      sync_violation_o <= next_violation;
      clock_request_o <= next_clock_request;
    end
  end

  // checks on the logic above
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_update_set_on: assert property ((wrap_i | retrig_i) |=> dma_update_o)
    else $error("update request missed a wrap or retrigger");
  a_update_drop_on: assert property (
    (!(wrap_i | retrig_i) && |(reg_write_i & UPD_CLR_MASK)) |=> !dma_update_o)
    else $error("update request not dropped by register write");
  a_flag_follow_wrap: assert property (
    (wrap_i && !irq_mask_set_i[IF_WRAP]) |=> irq_flags_o[IF_WRAP])
    else $error("wrap flag not set");
  a_irq_line_match: assert property (irq_o == |(irq_flags_o & irq_mask))
    else $error("irq line disagrees with flags and mask");
  a_mask_zero_hold: assert property (
    (irq_mask_set_i == '0 && irq_mask_clear_i == '0) |=> $stable(irq_mask))
    else $error("mask moved without a one written");
  a_event_gate_wrap: assert property (!event_out_enable_i.wrap |=> !event_out_o.wrap)
    else $error("wrap event while disabled");
  a_busy_on_write: assert property (
    (reg_write_i[SB_LENGTH] && !crossing_pending_flags_o[SB_LENGTH])
      |=> crossing_pending_flags_o[SB_LENGTH] [*1] ##1 1'b1)
    else $error("busy bit not set by write");
  a_violation_flag: assert property (
    |(reg_write_i & crossing_pending_flags_o) |=> sync_violation_o)
    else $error("busy access not reported");
  a_start_no_restart: assert property (counter_running_i |=> !counter_cmd_o.start)
    else $error("start issued while running");
  a_capt_err_flag: assert property (|capt_err |=> irq_flags_o[IF_CAPT_ERR])
    else $error("capture overrun not flagged");
  a_standby_stop: assert property (
    (standby_i && !keep_running_in_sleep_i) |=> !clock_request_o)
    else $error("clock kept in standby without request");
  a_cmp_dma_set: assert property (
    |(match_i & ~capture_mode_i) |=> |dma_channel_o)
    else $error("compare match gave no channel request");
  a_cmp_dma_clear: assert property (
    (reg_write_i[SB_COMPARE_BUF0] && !capture_mode_i[0] && !match_i[0]) |=> !dma_channel_o[0])
    else $error("compare buffer write kept channel request");
  a_capt_dma_free: assert property (
    (cc_read_i[1] && capture_mode_i[1] && !capture_i[1]) |=> !dma_channel_o[1])
    else $error("capture read kept channel request");
  a_sync_rdy_flag: assert property (|write_applied_o |=> irq_flags_o[IF_SYNC_RDY])
    else $error("finished crossing gave no ready flag");
  a_mask_clear_win: assert property (irq_mask_clear_i[IF_WRAP] |=> !irq_mask[IF_WRAP])
    else $error("mask clear did not disable");

  c_update_req: cover property (dma_update_o ##1 !dma_update_o);
  c_irq_raised: cover property (!irq_o ##1 irq_o);
  c_capt_overrun: cover property (|capt_err);
  c_sync_violate: cover property (sync_violation_o);
endmodule

// *** bench/trs_far_model.sv ***
// far-side stand-in: counting clock enables and a dma engine that drains capture requests
`timescale 1ns/100ps
module trs_far_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic read_en_i,
  input wire logic [trs_pkg::CH_NUM-1:0] dma_channel_i,
  input wire logic [trs_pkg::CH_NUM-1:0] capture_mode_i,
  output logic prescale_tick_o,
  output logic counting_tick_o,
  output logic [trs_pkg::CH_NUM-1:0] cc_read_o
);
  import trs_pkg::*;
  logic [2:0] div;
  logic [1:0] wait_cnt;
  // counting domain runs at a quarter rate so crossings take several bus cycles
  always_ff @(posedge clk_i) begin
    div <= rst_i ? 3'h0 : div + 3'h1;
  end
  assign counting_tick_o = (div[1:0] == 2'h3);
  assign prescale_tick_o = div[0];
  // dma engine reads a held capture after a short delay, one read per request
  always_ff @(posedge clk_i) begin
    cc_read_o <= '0;
    if (rst_i || !read_en_i || cc_read_o != '0) begin
      wait_cnt <= 2'h0;
    end else if ((dma_channel_i & capture_mode_i) != '0) begin
      wait_cnt <= wait_cnt + 2'h1;
      if (wait_cnt == 2'h2) begin
        cc_read_o <= dma_channel_i & capture_mode_i;
      end
    end
  end
endmodule

// *** bench/tb_trs_request_event.sv ***
// self-checking bench for the timer request, event and crossing block
`timescale 1ns/100ps
module tb_trs_request_event;
  import trs_pkg::*;
  localparam int TICKS = 3;
  logic clk_i = 1'h0, rst_i = 1'h1, wrap_i = 1'h0, retrig_i = 1'h0, count_i = 1'h0;
  logic debug_fault_i = 1'h0, counter_running_i = 1'h0, keep_running_in_sleep_i = 1'h0;
  logic standby_i = 1'h0, counter_event_zero_i = 1'h0, counter_event_one_i = 1'h0;
  logic read_en = 1'h0;
  logic [CH_NUM-1:0] match_i = '0, capture_i = '0, capture_mode_i = '0, channel_event_i = '0;
  logic [CH_NUM-1:0] channel_event_in_enable_i = '0, channel_fault_select_i = '0;
  logic [CH_NUM-1:0] cc_read_i, dma_channel_o, channel_capture_o, channel_fault_o;
  logic [1:0] rec_fault_i = 2'h0, counter_event_in_enable_i = 2'h0;
  logic [IRQ_W-1:0] irq_flags_clear_i = '0, irq_mask_set_i = '0, irq_mask_clear_i = '0;
  logic [IRQ_W-1:0] irq_flags_o;
  logic [SYNC_W-1:0] reg_write_i = '0, crossing_pending_flags_o, write_applied_o;
  trs_event_out_t event_out_enable_i = '0, event_out_o;
  trs_ev0_act_t event_zero_action_select_i = A0_OFF;
  trs_ev1_act_t event_one_action_select_i = A1_OFF;
  trs_counter_cmd_t counter_cmd_o;
  logic prescale_tick_i, counting_tick_i, dma_update_o, irq_o, clock_request_o, wake_o;
  logic sync_violation_o;
  int fail_count = 0, n_tests = 0;

  trs_request_event #(.SYNC_TICKS(TICKS)) dut (.clk_i, .rst_i, .wrap_i, .retrig_i, .count_i,
    .match_i, .capture_i, .cc_read_i, .capture_mode_i, .debug_fault_i, .rec_fault_i,
    .irq_flags_clear_i, .irq_mask_set_i, .irq_mask_clear_i, .event_out_enable_i,
    .channel_event_in_enable_i, .channel_fault_select_i, .counter_event_in_enable_i,
    .event_zero_action_select_i, .event_one_action_select_i, .counter_event_zero_i,
    .counter_event_one_i, .channel_event_i, .prescale_tick_i, .counting_tick_i,
    .counter_running_i, .keep_running_in_sleep_i, .standby_i, .reg_write_i, .dma_update_o,
    .dma_channel_o, .irq_o, .irq_flags_o, .event_out_o, .counter_cmd_o, .channel_capture_o,
    .channel_fault_o, .clock_request_o, .wake_o, .crossing_pending_flags_o, .write_applied_o,
    .sync_violation_o);
  trs_far_model far (.clk_i, .rst_i, .read_en_i(read_en), .dma_channel_i(dma_channel_o),
    .capture_mode_i, .prescale_tick_o(prescale_tick_i), .counting_tick_o(counting_tick_i),
    .cc_read_o(cc_read_i));

  initial begin
    forever #10 clk_i = ~clk_i;
  end

  task automatic chk(input bit ok, input string msg);
    n_tests++;
    if (!ok) begin
      fail_count++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask

  // step clocks, dropping every strobe after each edge so none lingers
  task automatic cyc(input int n = 1);
    repeat (n) begin
      @(posedge clk_i);
      #1;
      {wrap_i, retrig_i, count_i, debug_fault_i, rec_fault_i, match_i, capture_i} = '0;
      {irq_flags_clear_i, irq_mask_set_i, irq_mask_clear_i, reg_write_i} = '0;
    end
  endtask

  task automatic wait_idle();
    for (int i = 0; i < 80 && crossing_pending_flags_o != '0; i++) cyc();
    chk(crossing_pending_flags_o === '0, "crossing stuck busy");
  endtask

  task automatic close_out();
    if (fail_count == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic s_flags();
    event_out_enable_i = 7'h7f;
    irq_mask_set_i = 20'h00001;
    cyc(2);
    wrap_i = 1'h1;
    cyc();
    chk(dma_update_o === 1'h1, "no update request on wrap");
    chk(irq_flags_o[IF_WRAP] === 1'h1 && event_out_o.wrap === 1'h1, "wrap flag or event");
    chk(irq_o === 1'h1 && wake_o === 1'h1, "enabled flag raised no irq");
    cyc();
    chk(event_out_o.wrap === 1'h0 && irq_o === 1'h1, "event length or irq hold");
    irq_mask_clear_i = 20'h00001;
    cyc(2);
    chk(irq_o === 1'h0 && irq_flags_o[IF_WRAP] === 1'h1, "mask clear ignored");
    irq_mask_set_i = 20'h00001;
    cyc(2);
    chk(irq_o === 1'h1, "mask set ignored");
    irq_flags_clear_i = 20'h00001;
    cyc(2);
    chk(irq_o === 1'h0 && irq_flags_o === 20'h00000, "flag clear kept irq");
    {retrig_i, count_i} = 2'h3;
    cyc();
    chk(event_out_o === 7'h30, "retrigger or count event missing");
    // sources fire with events off and masks closed: flags still set, line quiet
    event_out_enable_i = '0;
    {retrig_i, count_i, debug_fault_i, rec_fault_i} = 5'h1f;
    cyc();
    chk(irq_flags_o === 20'h03806, "flags of masked sources");
    chk(irq_o === 1'h0 && event_out_o === '0, "irq or disabled events");
    chk(dma_update_o === 1'h1, "no update request on retrigger");
    irq_flags_clear_i = 20'hfffff;
    cyc(2);
  endtask

  task automatic s_sync();
    int k;
    logic hit;
    for (int i = 0; i < 23; i++) begin
      if (i > 11 && i < 16) continue;
      retrig_i = 1'h1;
      cyc();
      chk(dma_update_o === 1'h1, "no update request on retrigger");
      reg_write_i[i] = 1'h1;
      cyc();
      chk(dma_update_o === !UPD_CLR_MASK[i], "update request after write");
      chk(crossing_pending_flags_o[i] === 1'h1, "write not flagged busy");
      wait_idle();
    end
    irq_flags_clear_i = 20'hfffff;
    cyc();
    reg_write_i[SB_LENGTH] = 1'h1;
    cyc();
    reg_write_i[SB_LENGTH] = 1'h1;
    hit = 1'h0;
    repeat (2) begin
      cyc();
      hit |= sync_violation_o;
    end
    chk(hit === 1'h1, "busy write not reported");
    for (k = 0; k < 60 && crossing_pending_flags_o[SB_LENGTH] !== 1'h0; k++) cyc();
    chk(k >= 4 && write_applied_o[SB_LENGTH] === 1'h1, "crossing timing or applied");
    cyc();
    chk(irq_flags_o[IF_SYNC_RDY] === 1'h1, "no sync ready flag");
    irq_flags_clear_i = 20'hfffff;
    cyc();
  endtask

  task automatic s_chan();
    int k;
    event_out_enable_i = 7'h0f;
    match_i = 4'h1;
    cyc();
    chk(dma_channel_o[0] === 1'h1 && irq_flags_o[IF_MATCH0] === 1'h1, "match request");
    chk(event_out_o.match === 4'h1, "match event");
    cyc(3);
    reg_write_i[SB_COMPARE_BUF0] = 1'h1;
    cyc();
    chk(dma_channel_o[0] === 1'h0, "buffer write kept request");
    wait_idle();
    capture_mode_i = 4'h2;
    capture_i = 4'h2;
    cyc(4);
    chk(dma_channel_o[1] === 1'h1, "capture request not held");
    capture_i = 4'h2;
    cyc(2);
    chk(irq_flags_o[IF_CAPT_ERR] === 1'h1, "no capture overflow");
    read_en = 1'h1;
    for (k = 0; k < 10 && dma_channel_o[1] !== 1'h0; k++) cyc();
    chk(dma_channel_o[1] === 1'h0 && k > 1, "read did not release");
    read_en = 1'h0;
    capture_mode_i = '0;
    irq_flags_clear_i = 20'hfffff;
    cyc();
  endtask

  // pulse one event pin three cycles and count cycles the watched output is high
  task automatic ev_try(input int pin, input int idx, input int mode, input string msg);
    logic [12:0] obs;
    int hits;
    hits = 0;
    if (pin == 0) counter_event_zero_i = 1'h1;
    else if (pin == 1) counter_event_one_i = 1'h1;
    else channel_event_i = 4'h1;
    for (int t = 0; t < 12; t++) begin
      if (t == 3) {counter_event_zero_i, counter_event_one_i, channel_event_i} = '0;
      cyc();
      obs = {counter_cmd_o, channel_capture_o[0], channel_fault_o[0]};
      if (obs[idx] === 1'h1) hits++;
    end
    chk(mode == 0 ? hits == 0 : (mode == 1 ? hits == 1 : hits > 0), msg);
  endtask

  task automatic s_events();
    int code[6] = '{1, 2, 3, 4, 5, 7};
    int bit0[6] = '{12, 11, 10, 9, 11, 3};
    int bit1[6] = '{12, 7, 6, 8, 5, 2};
    counter_event_in_enable_i = 2'h3;
    for (int i = 0; i < 6; i++) begin
      event_zero_action_select_i = trs_ev0_act_t'(code[i]);
      event_one_action_select_i = trs_ev1_act_t'(code[i]);
      cyc(2);
      ev_try(0, bit0[i], (i == 2 || i == 3) ? 1 : 2, "event zero action");
      ev_try(1, bit1[i], 2, "event one action");
    end
    event_one_action_select_i = A1_PWP;
    ev_try(1, 4, 1, "width capture on rising edge");
    event_zero_action_select_i = A0_START;
    counter_running_i = 1'h1;
    ev_try(0, 10, 0, "start while running");
    counter_running_i = 1'h0;
    event_zero_action_select_i = A0_INC;
    counter_event_in_enable_i = 2'h0;
    ev_try(0, 9, 0, "disabled counter event acted");
    channel_event_in_enable_i = 4'h1;
    ev_try(2, 1, 2, "no capture on channel event");
    channel_fault_select_i = 4'h1;
    ev_try(2, 0, 2, "no fault on channel event");
    channel_event_in_enable_i = 4'h0;
    ev_try(2, 0, 0, "disabled channel event acted");
  endtask

  // a reset in mid-run must drop a live interrupt and every flag
  task automatic s_reset();
    irq_mask_set_i = 20'h00004;
    count_i = 1'h1;
    cyc();
    chk(irq_o === 1'h1, "count flag raised no irq");
    rst_i = 1'h1;
    cyc(3);
    rst_i = 1'h0;
    cyc();
    chk(irq_o === 1'h0 && irq_flags_o === IRQ_RST, "reset kept irq or flags");
  endtask

  task automatic s_sleep();
    standby_i = 1'h1;
    cyc(3);
    chk(clock_request_o === 1'h0, "clock kept in standby");
    keep_running_in_sleep_i = 1'h1;
    cyc(3);
    chk(clock_request_o === 1'h1, "clock dropped though asked to run");
  endtask

  initial begin
    cyc(20);
    rst_i = 1'h0;
    cyc();
    chk(clock_request_o === 1'h1 && irq_flags_o === IRQ_RST, "reset state");
    chk(crossing_pending_flags_o === SYNC_RST && dma_update_o === 1'h0, "reset busy state");
    s_flags();
    s_sync();
    s_chan();
    s_events();
    s_reset();
    s_sleep();
    close_out();
  end

  // watchdog sized well past the expected run of several hundred cycles
  initial begin
    #400000;
    fail_count++;
    close_out();
  end
endmodule
